/* File: shared/cbe_pkg.sv */
// Constants and types for the conditional branch evaluator
package cbe_pkg;

  localparam int PC_WIDTH_DEF     = 16;
  localparam int OFFSET_WIDTH_DEF = 7;
  localparam int STATUS_WIDTH     = 8;

  // Flag positions inside the status register
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  // Derived signed-sign bit sits just above the status bits
  localparam int COND_WIDTH     = STATUS_WIDTH + 1;
  localparam int COND_SEL_WIDTH = 4;
  localparam int COND_SIGNED    = STATUS_WIDTH;

  localparam int PC_RESET   = 0;
  localparam int PC_STEP    = 1;
  localparam int BIT_SEL_W  = 3;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER_UNSIGNED,
    OP_BRANCH_NEGATIVE,
    OP_BRANCH_POSITIVE,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LESS,
    OP_BRANCH_HALFCARRY_SET,
    OP_BRANCH_HALFCARRY_CLEAR,
    OP_BRANCH_STATUS_BIT_SET,
    OP_BRANCH_STATUS_BIT_CLEAR
  } cbe_op_t;

  typedef enum logic {
    ST_EXEC,
    ST_FLUSH
  } cbe_state_t;

endpackage

/* File: logic/cbe_bit_test.sv */
// Single selected condition bit test against a wanted polarity
`timescale 1ns/100ps
module cbe_bit_test #(
  parameter int WIDTH     = 9,
  parameter int SEL_WIDTH = 4
) (
  input  wire logic [WIDTH-1:0]     cond_vec,
  input  wire logic [SEL_WIDTH-1:0] sel,
  input  wire logic                 want_set,
  output logic                      hit
);

  logic picked;

  assign picked = cond_vec[sel];
  assign hit    = (picked == want_set);

endmodule // cbe_bit_test

/* File: logic/cbe_branch_eval.sv */
// Conditional relative branch evaluation and program counter update
`timescale 1ns/100ps

// Overview of operation
// - Carry-clear branch jumps to pc plus offset plus one when C is 0, alters no flag, takes one or two cycles.
// - Same-or-higher branch is evaluated exactly like carry-clear.
// - Lower branch jumps to pc plus offset plus one when C is 1 and alters no flag.
// - Minus branch jumps when N is 1 and takes one or two cycles.
// - Plus branch jumps when N is 0 and leaves every flag alone.
// - Signed greater-or-equal branch jumps when N xor V is 0.
// - Signed less-than branch jumps when N xor V is 1 and alters no flag.
// - Half-carry-set branch jumps when H is 1 in one or two cycles.
// - Half-carry-clear branch jumps when H is 0 without changing any flag.
// - Every named branch except the two signed ones is a case of one generic test of a selected status bit for set or clear; those test the derived N xor V bit.
module cbe_branch_eval
  import cbe_pkg::*;
#(
  parameter int PC_WIDTH     = PC_WIDTH_DEF,
  parameter int OFFSET_WIDTH = OFFSET_WIDTH_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    issue_valid,
  input  wire cbe_op_t                 branch_op,
  input  wire logic [BIT_SEL_W-1:0]    status_bit_sel,
  input  wire logic [OFFSET_WIDTH-1:0] branch_offset,
  input  wire logic [STATUS_WIDTH-1:0] status_register,
  output logic                         issue_ready,
  output logic                         flush_fetch,
  output logic                         branch_taken_reg,
  output logic [PC_WIDTH-1:0]          pc_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode

  cbe_state_t                state_reg;
  cbe_state_t                state_next;
  logic [PC_WIDTH-1:0]       pc_next;
  logic [COND_WIDTH-1:0]     cond_vec;
  logic [COND_SEL_WIDTH-1:0] test_sel;
  logic                      test_want_set;
  logic                      is_branch;
  logic                      cond_hit;
  logic                      accept;
  logic                      taken;
  logic [PC_WIDTH-1:0]       offset_ext;
  logic [PC_WIDTH-1:0]       target;
  logic [PC_WIDTH-1:0]       pc_seq;

  // Signed tests see N xor V as one extra bit above the flags
  assign cond_vec = {status_register[FLAG_N] ^ status_register[FLAG_V],
                     status_register};

  always_comb begin
    test_sel      = COND_SEL_WIDTH'(FLAG_C);
    test_want_set = 1'b0;
    is_branch     = 1'b1;
    case (branch_op)
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: begin
        test_sel      = COND_SEL_WIDTH'(FLAG_C);
        test_want_set = 1'b0;
      end
      OP_BRANCH_LOWER_UNSIGNED: begin
        test_sel      = COND_SEL_WIDTH'(FLAG_C);
        test_want_set = 1'b1;
      end
      OP_BRANCH_NEGATIVE: begin
        test_sel      = COND_SEL_WIDTH'(FLAG_N);
        test_want_set = 1'b1;
      end
      OP_BRANCH_POSITIVE: begin
        test_sel      = COND_SEL_WIDTH'(FLAG_N);
        test_want_set = 1'b0;
      end
      OP_BRANCH_SIGNED_GE: begin
        test_sel      = COND_SEL_WIDTH'(COND_SIGNED);
        test_want_set = 1'b0;
      end
      OP_BRANCH_SIGNED_LESS: begin
        test_sel      = COND_SEL_WIDTH'(COND_SIGNED);
        test_want_set = 1'b1;
      end
      OP_BRANCH_HALFCARRY_SET: begin
        test_sel      = COND_SEL_WIDTH'(FLAG_H);
        test_want_set = 1'b1;
      end
      OP_BRANCH_HALFCARRY_CLEAR: begin
        test_sel      = COND_SEL_WIDTH'(FLAG_H);
        test_want_set = 1'b0;
      end
      OP_BRANCH_STATUS_BIT_SET: begin
        test_sel      = COND_SEL_WIDTH'(status_bit_sel);
        test_want_set = 1'b1;
      end
      OP_BRANCH_STATUS_BIT_CLEAR: begin
        test_sel      = COND_SEL_WIDTH'(status_bit_sel);
        test_want_set = 1'b0;
      end
      default: begin
        is_branch = 1'b0;
      end
    endcase
  end

  cbe_bit_test #(
    .WIDTH     (COND_WIDTH),
    .SEL_WIDTH (COND_SEL_WIDTH)
  ) u_bit_test (
    .cond_vec (cond_vec),
    .sel      (test_sel),
    .want_set (test_want_set),
    .hit      (cond_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Target arithmetic

  assign offset_ext = {{(PC_WIDTH-OFFSET_WIDTH){branch_offset[OFFSET_WIDTH-1]}},
                       branch_offset};
  assign target     = pc_reg + offset_ext + PC_WIDTH'(PC_STEP);
  assign pc_seq     = pc_reg + PC_WIDTH'(PC_STEP);

  assign issue_ready = (state_reg == ST_EXEC);
  assign flush_fetch = (state_reg == ST_FLUSH);
  assign accept      = issue_valid && issue_ready;
  assign taken       = accept && is_branch && cond_hit;
  assign pc_next     = !accept ? pc_reg : (taken ? target : pc_seq);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: a taken branch spends one extra cycle flushing

  always_comb begin
    case (state_reg)
      ST_EXEC:  state_next = taken ? ST_FLUSH : ST_EXEC;
      ST_FLUSH: state_next = ST_EXEC;
      default:  state_next = ST_EXEC;
    endcase
  end

  // Status flags are only read here; no write path exists
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg        <= ST_EXEC;
      pc_reg           <= PC_WIDTH'(PC_RESET);
      branch_taken_reg <= 1'b0;
    end else begin
      state_reg        <= state_next;
      pc_reg           <= pc_next;
      branch_taken_reg <= taken;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_carry_clear_target: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_CARRY_CLEAR && !status_register[FLAG_C]
    |=> pc_reg == PC_WIDTH'($past(pc_reg) + $past(offset_ext) + 1)
        && flush_fetch ##1 issue_ready)
    else $error("carry clear branch did not reach its target");

  a_carry_set_falls: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_CARRY_CLEAR && status_register[FLAG_C]
    |=> pc_reg == PC_WIDTH'($past(pc_reg) + 1) && issue_ready)
    else $error("carry clear branch not-taken path wrong");

  a_same_higher_cond: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_SAME_OR_HIGHER
    |=> branch_taken_reg == !$past(status_register[FLAG_C]))
    else $error("same or higher branch decision wrong");

  a_lower_cond: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_LOWER_UNSIGNED
    |=> branch_taken_reg == $past(status_register[FLAG_C]))
    else $error("lower branch decision wrong");

  a_minus_two_cycles: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_NEGATIVE && status_register[FLAG_N]
    |=> !issue_ready ##1 issue_ready)
    else $error("minus branch did not take two cycles");

  a_plus_target: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_POSITIVE && !status_register[FLAG_N]
    |=> pc_reg == PC_WIDTH'($past(pc_reg) + $past(offset_ext) + 1))
    else $error("plus branch target wrong");

  a_signed_ge_cond: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_SIGNED_GE
    |=> branch_taken_reg ==
        !($past(status_register[FLAG_N]) ^ $past(status_register[FLAG_V])))
    else $error("signed greater-or-equal decision wrong");

  a_signed_lt_cond: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_SIGNED_LESS
    |=> branch_taken_reg ==
        ($past(status_register[FLAG_N]) ^ $past(status_register[FLAG_V])))
    else $error("signed less-than decision wrong");

  a_halfcarry_set: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_HALFCARRY_SET
    |=> branch_taken_reg == $past(status_register[FLAG_H]))
    else $error("half carry set decision wrong");

  a_halfcarry_clear: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_HALFCARRY_CLEAR
    |=> branch_taken_reg == !$past(status_register[FLAG_H]))
    else $error("half carry clear decision wrong");

  a_generic_bit_set: assert property (
    @(posedge clk) disable iff (srst)
    accept && branch_op == OP_BRANCH_STATUS_BIT_SET
    |=> branch_taken_reg == $past(status_register[status_bit_sel]))
    else $error("generic bit-set branch decision wrong");

  a_flush_follows: assert property (
    @(posedge clk) disable iff (srst)
    flush_fetch |-> branch_taken_reg && !issue_ready
    ##1 !flush_fetch && $stable(pc_reg))
    else $error("flush cycle not tied to a taken branch");

  a_back_offset: assert property (
    @(posedge clk) disable iff (srst)
    taken && (&branch_offset) |=> pc_reg == $past(pc_reg))
    else $error("minus one offset not sign-extended");

endmodule // cbe_branch_eval

/* File: verification/cbe_branch_eval_tb_top.sv */
// Self-checking testbench for the conditional branch evaluator
`timescale 1ns/100ps
module cbe_branch_eval_tb_top;
  import cbe_pkg::*;

  logic        clk;
  logic        srst;
  logic        issue_valid;
  cbe_op_t     branch_op;
  logic [2:0]  status_bit_sel;
  logic [6:0]  branch_offset;
  logic [7:0]  status_register;
  logic        issue_ready;
  logic        flush_fetch;
  logic        branch_taken_reg;
  logic [15:0] pc_reg;
  logic [15:0] exp_pc;
  int          bad_count;
  int          comparisons;
  int          cycle_count;

  cbe_branch_eval cbe_branch_eval_inst (
    .clk              (clk),
    .srst             (srst),
    .issue_valid      (issue_valid),
    .branch_op        (branch_op),
    .status_bit_sel   (status_bit_sel),
    .branch_offset    (branch_offset),
    .status_register  (status_register),
    .issue_ready      (issue_ready),
    .flush_fetch      (flush_fetch),
    .branch_taken_reg (branch_taken_reg),
    .pc_reg           (pc_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One instruction; a taken one is followed by a refused would-be branch
  task automatic run_op(input cbe_op_t op, input logic [7:0] flags,
                        input logic [6:0] k, input logic tk,
                        input logic [2:0] sel = 3'h0);
    issue_valid     = 1'b1;
    branch_op       = op;
    status_register = flags;
    branch_offset   = k;
    status_bit_sel  = sel;
    @(negedge clk);
    exp_pc = tk ? exp_pc + {{9{k[6]}}, k} + 16'h0001 : exp_pc + 16'h0001;
    check("pc_reg", exp_pc, pc_reg);
    check("branch_taken_reg", 16'(tk), 16'(branch_taken_reg));
    check("flush_fetch", 16'(tk), 16'(flush_fetch));
    check("issue_ready", 16'(!tk), 16'(issue_ready));
    if (tk) begin
      branch_op       = OP_BRANCH_STATUS_BIT_SET;
      status_register = 8'hFF;
      @(negedge clk);
      check("pc_reg held", exp_pc, pc_reg);
      check("taken pulse", 16'h0000, 16'(branch_taken_reg));
      check("flush end", 16'h0000, 16'(flush_fetch));
      check("ready back", 16'h0001, 16'(issue_ready));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic carry_tests();
    run_op(OP_BRANCH_CARRY_CLEAR, 8'hFE, 7'h05, 1'b1);
    run_op(OP_BRANCH_CARRY_CLEAR, 8'h01, 7'h05, 1'b0);
    run_op(OP_BRANCH_SAME_OR_HIGHER, 8'hFE, 7'h11, 1'b1);
    run_op(OP_BRANCH_SAME_OR_HIGHER, 8'h01, 7'h11, 1'b0);
    run_op(OP_BRANCH_LOWER_UNSIGNED, 8'h01, 7'h02, 1'b1);
    run_op(OP_BRANCH_LOWER_UNSIGNED, 8'hFE, 7'h02, 1'b0);
  endtask

  task automatic sign_tests();
    run_op(OP_BRANCH_NEGATIVE, 8'h04, 7'h7E, 1'b1);
    run_op(OP_BRANCH_NEGATIVE, 8'hFB, 7'h7E, 1'b0);
    run_op(OP_BRANCH_POSITIVE, 8'hFB, 7'h09, 1'b1);
    run_op(OP_BRANCH_POSITIVE, 8'h04, 7'h09, 1'b0);
  endtask

  task automatic signed_tests();
    run_op(OP_BRANCH_SIGNED_GE, 8'h0C, 7'h03, 1'b1);
    run_op(OP_BRANCH_SIGNED_GE, 8'h00, 7'h03, 1'b1);
    run_op(OP_BRANCH_SIGNED_GE, 8'h08, 7'h03, 1'b0);
    run_op(OP_BRANCH_SIGNED_LESS, 8'h04, 7'h7C, 1'b1);
    run_op(OP_BRANCH_SIGNED_LESS, 8'h08, 7'h7C, 1'b1);
    run_op(OP_BRANCH_SIGNED_LESS, 8'h0C, 7'h7C, 1'b0);
  endtask

  task automatic half_tests();
    run_op(OP_BRANCH_HALFCARRY_SET, 8'h20, 7'h10, 1'b1);
    run_op(OP_BRANCH_HALFCARRY_SET, 8'hDF, 7'h10, 1'b0);
    run_op(OP_BRANCH_HALFCARRY_CLEAR, 8'hDF, 7'h01, 1'b1);
    run_op(OP_BRANCH_HALFCARRY_CLEAR, 8'h20, 7'h01, 1'b0);
  endtask

  task automatic generic_tests();
    logic [7:0] one_hot;
    for (int s = 0; s < 8; s++) begin
      one_hot = 8'h01 << s;
      run_op(OP_BRANCH_STATUS_BIT_SET, one_hot, 7'h04, 1'b1, 3'(s));
      run_op(OP_BRANCH_STATUS_BIT_SET, ~one_hot, 7'h04, 1'b0, 3'(s));
      run_op(OP_BRANCH_STATUS_BIT_CLEAR, ~one_hot, 7'h7F, 1'b1, 3'(s));
      run_op(OP_BRANCH_STATUS_BIT_CLEAR, one_hot, 7'h7F, 1'b0, 3'(s));
    end
  endtask

  // Reset landing in the flush cycle of a taken branch
  task automatic reset_test();
    issue_valid     = 1'b1;
    branch_op       = OP_BRANCH_STATUS_BIT_SET;
    status_register = 8'hFF;
    status_bit_sel  = 3'h0;
    branch_offset   = 7'h08;
    @(negedge clk);
    srst        = 1'b1;
    issue_valid = 1'b0;
    @(negedge clk);
    srst   = 1'b0;
    exp_pc = 16'h0000;
    check("pc_reg rerst", exp_pc, pc_reg);
    check("taken rerst", 16'h0000, 16'(branch_taken_reg));
    check("flush rerst", 16'h0000, 16'(flush_fetch));
    check("ready rerst", 16'h0001, 16'(issue_ready));
  endtask

  // Extreme offsets, including a wrap below address zero
  task automatic offset_tests();
    run_op(OP_NONE, 8'hFF, 7'h40, 1'b0);
    run_op(OP_BRANCH_STATUS_BIT_SET, 8'hFF, 7'h3F, 1'b1);
    run_op(OP_BRANCH_STATUS_BIT_SET, 8'hFF, 7'h40, 1'b1);
    run_op(OP_BRANCH_STATUS_BIT_SET, 8'hFF, 7'h40, 1'b1);
    run_op(OP_BRANCH_STATUS_BIT_SET, 8'hFF, 7'h40, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count       = 0;
    comparisons     = 0;
    cycle_count     = 0;
    exp_pc          = 16'h0000;
    srst            = 1'b1;
    issue_valid     = 1'b0;
    branch_op       = OP_NONE;
    status_bit_sel  = 3'h0;
    branch_offset   = 7'h00;
    status_register = 8'h00;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    check("pc_reg reset", 16'h0000, pc_reg);
    check("ready reset", 16'h0001, 16'(issue_ready));
    check("flush reset", 16'h0000, 16'(flush_fetch));
    check("taken reset", 16'h0000, 16'(branch_taken_reg));
    carry_tests();
    sign_tests();
    signed_tests();
    half_tests();
    generic_tests();
    reset_test();
    offset_tests();
    issue_valid = 1'b0;
    repeat (3) @(negedge clk);
    check("pc_reg idle", exp_pc, pc_reg);
    conclude();
  end
endmodule // cbe_branch_eval_tb_top
